// ===== common/eeprom_pkg.sv
/*
 * Shared constants and types for the two-wire EEPROM read path.
 * Assumes a single 10 MHz system clock on both ends of the link.
 */
package eeprom_pkg;

   // ******************************
   // Timing
   // ******************************
   localparam int CLK_NS      = 100;
   localparam int SCL_QTR_NS  = 2500;
   localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] QTR_RELOAD = 8'(SCL_QTR_CYC - 1);

   // ******************************
   // Address space
   // ******************************
   localparam int ADDR_W     = 12;
   localparam int MAIN_BYTES = 4096;
   localparam int ID_BYTES   = 32;
   localparam int SER_BYTES  = 16;
   localparam int ID_IDX_W   = 5;
   localparam int SER_IDX_W  = 4;
   localparam int PAGE_W     = 5;
   localparam int BYTE_MSB   = 7;
   localparam int HI_LOCK_BIT = 2;
   localparam logic [ADDR_W-1:0]  ADDR_ONE   = 12'h001;
   localparam logic [PAGE_W-1:0]  PAGE_ONE   = 5'h01;
   localparam logic [ADDR_W-1:0]  ADDR_RESET = 12'h000;
   localparam logic [1:0]  REGION_ID  = 2'h0;
   localparam logic [1:0]  REGION_SER = 2'h2;
   localparam logic [7:0]  UNDEF_BYTE = 8'hff;

   // ******************************
   // Address byte layout
   // ******************************
   localparam logic [3:0] TYPE_MAIN = 4'ha;
   localparam logic [3:0] TYPE_ALT  = 4'hb;
   localparam logic       RW_READ   = 1'b1;
   localparam logic       RW_WRITE  = 1'b0;
   localparam logic [3:0] HI_PAD    = 4'h0;

   // ******************************
   // Bit counters
   // ******************************
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [3:0] BIT_ONE  = 4'h1;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_BYTE = 4'h8;
   localparam logic [3:0] BIT_ACK  = 4'h9;
   localparam logic [7:0] CNT_ONE  = 8'h01;

   // ******************************
   // Types
   // ******************************
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_DEV  = 3'b001,
      D_AHI  = 3'b011,
      D_ALO  = 3'b010,
      D_WDAT = 3'b110,
      D_RD   = 3'b111
   } dev_state_e;

   typedef enum logic [2:0] {
      H_IDLE  = 3'b000,
      H_START = 3'b001,
      H_TX    = 3'b011,
      H_RX    = 3'b010,
      H_STOP  = 3'b110
   } host_state_e;

   typedef enum logic [1:0] {
      K_DEVW = 2'b00,
      K_AHI  = 2'b01,
      K_ALO  = 2'b11,
      K_DEVR = 2'b10
   } tx_kind_e;

   typedef enum logic [1:0] {
      LD_MAIN = 2'b00,
      LD_ID   = 2'b01,
      LD_SER  = 2'b10
   } load_sel_e;

endpackage

// ===== common/eeprom_link_if.sv
/*
 * Two-wire link between the bus master and the EEPROM.
 * Assumes an external pull-up: SDA is high unless an end pulls it low.
 */
`timescale 1ns/1ns
interface eeprom_link_if;
   logic scl;
   logic sda;
   logic host_sda_out;
   logic host_sda_en_n;
   logic dev_sda_out;
   logic dev_sda_en_n;

   // Wired-AND with pull-up
   assign sda = (host_sda_en_n | host_sda_out) & (dev_sda_en_n | dev_sda_out);

   modport device (
      input  scl,
      input  sda,
      output dev_sda_out,
      output dev_sda_en_n
   );

   modport host (
      output scl,
      output host_sda_out,
      output host_sda_en_n,
      input  sda
   );
endinterface

// ===== design/eeprom_read_device.sv
/*
 * EEPROM slave end of the two-wire link: read path, address pointer,
 * identification page, lock probe and serial number block.
 * Assumes SCL and SDA come asynchronously from the link; contents are
 * preloaded through the load port (programming is not modelled).
 */
`timescale 1ns/1ns

// Operation
// - Direction bit one selects a read
// - Pointer holds last accessed address plus one
// - Pointer survives between transactions
// - Read wraps from last byte to zero
// - Acked read address sends current byte MSB-first
// - Master ends read with no-ack, stop
// - Random read: dummy write, restart, read
// - Loaded word address is read next
// - Master ack advances pointer, next byte
// - Sequential read wraps without interruption
// - ID page: type 1011b, A11:A10 00
// - Master stays within ID page boundary
// - ID data byte acked only if unlocked
// - Serial needs A11:A10 10, else undefined
// - Master reads full serial from start
// - One pointer shared by array and serial
// - Master dummy-writes before serial read
// - Serial read ends with no-ack, stop
// - Ack address only if select bits match
// - Alternate type 1011b for extra areas
module eeprom_read_device
   import eeprom_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Link
   eeprom_link_if.device             link,
   // Select straps
   input  wire logic                 chip_select_bit_high,
   input  wire logic                 chip_select_bit_mid,
   input  wire logic                 chip_select_bit_low,
   // Lock state of the identification page
   input  wire logic                 id_locked,
   // Contents preload
   input  wire logic                 load_en,
   input  eeprom_pkg::load_sel_e     load_sel,
   input  wire logic [ADDR_W-1:0]    load_addr,
   input  wire logic [7:0]           load_data,
   // Status
   output logic                      selected
);
   import eeprom_pkg::*;

   // ******************************
   // Storage
   // ******************************
   logic [7:0] main_mem [MAIN_BYTES];
   logic [7:0] id_mem   [ID_BYTES];
   logic [7:0] ser_mem  [SER_BYTES];

   always_ff @(posedge clk) begin
      if (load_en) begin
         unique case (load_sel)
            LD_MAIN: main_mem[load_addr] <= load_data;
            LD_ID:   id_mem[load_addr[ID_IDX_W-1:0]] <= load_data;
            LD_SER:  ser_mem[load_addr[SER_IDX_W-1:0]] <= load_data;
            default: ;
         endcase
      end
   end

   // ******************************
   // Input synchronisers
   // ******************************
   logic       scl_m, scl_s, scl_d;
   logic       sda_m, sda_s, sda_d;
   logic [2:0] cs_m, cs_s;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
         cs_m  <= 3'h0;
         cs_s  <= 3'h0;
      end else begin
         scl_m <= link.scl;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= link.sda;
         sda_s <= sda_m;
         sda_d <= sda_s;
         cs_m  <= {chip_select_bit_high, chip_select_bit_mid,
                   chip_select_bit_low};
         cs_s  <= cs_m;
      end
   end

   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   // ******************************
   // Protocol state
   // ******************************
   dev_state_e        state, next_state, pending, next_pending;
   logic [3:0]        bitcnt, next_bitcnt;
   logic [7:0]        shreg, next_shreg, outbyte, next_outbyte;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [3:0]        ahi, next_ahi;
   logic              alt, next_alt, mack, next_mack;
   logic              sda_en_n, next_sda_en_n, next_selected;
   logic [7:0]        rd_byte;
   logic              type_ok, match;

   // Out-of-area alternate reads return a fixed filler value
   always_comb begin
      rd_byte = UNDEF_BYTE;
      if (!alt) begin
         rd_byte = main_mem[addr];
      end else if (ahi[3:2] == REGION_ID) begin
         rd_byte = id_mem[addr[ID_IDX_W-1:0]];
      end else if (ahi[3:2] == REGION_SER) begin
         rd_byte = ser_mem[addr[SER_IDX_W-1:0]];
      end
   end

   assign type_ok = (shreg[7:4] == TYPE_MAIN) ||
                    (shreg[7:4] == TYPE_ALT);
   assign match   = type_ok && (shreg[3:1] == cs_s);

   always_comb begin
      next_state    = state;
      next_pending  = pending;
      next_bitcnt   = bitcnt;
      next_shreg    = shreg;
      next_outbyte  = outbyte;
      next_addr     = addr;
      next_ahi      = ahi;
      next_alt      = alt;
      next_mack     = mack;
      next_sda_en_n = sda_en_n;
      if (stop_c) begin
         next_state    = D_IDLE;
         next_sda_en_n = 1'b1;
      end else if (start_c) begin
         next_state    = D_DEV;
         next_bitcnt   = BIT_ZERO;
         next_sda_en_n = 1'b1;
      end else if (state == D_RD) begin
         if (scl_rise && bitcnt == BIT_ACK) begin
            next_mack = ~sda_s;
         end
         if (scl_fall) begin
            if (bitcnt < BIT_BYTE) begin
               next_sda_en_n = outbyte[~bitcnt[2:0]];
               next_bitcnt   = bitcnt + BIT_ONE;
            end else if (bitcnt == BIT_BYTE) begin
               // Full 12-bit wrap, no page roll on reads
               next_sda_en_n = 1'b1;
               next_addr     = addr + ADDR_ONE;
               next_bitcnt   = BIT_ACK;
            end else if (mack) begin
               next_outbyte  = rd_byte;
               next_sda_en_n = rd_byte[BYTE_MSB];
               next_bitcnt   = BIT_ONE;
            end else begin
               // No-ack: release and wait for stop
               next_state = D_IDLE;
            end
         end
      end else if (state != D_IDLE) begin
         if (scl_rise && bitcnt < BIT_BYTE) begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + BIT_ONE;
         end
         if (scl_fall && bitcnt == BIT_BYTE) begin
            next_bitcnt   = BIT_ACK;
            next_sda_en_n = 1'b0;
            unique case (state)
               D_DEV: begin
                  if (match) begin
                     next_alt     = (shreg[7:4] == TYPE_ALT);
                     next_pending = (shreg[0] == RW_READ) ?
                                    D_RD : D_AHI;
                  end else begin
                     next_state    = D_IDLE;
                     next_sda_en_n = 1'b1;
                  end
               end
               D_AHI: begin
                  next_ahi     = shreg[3:0];
                  next_pending = D_ALO;
               end
               D_ALO: begin
                  next_addr    = {ahi, shreg};
                  next_pending = D_WDAT;
               end
               D_WDAT: begin
                  if (alt && id_locked) begin
                     next_sda_en_n = 1'b1;
                  end else begin
                     next_addr = {addr[ADDR_W-1:PAGE_W],
                                  addr[PAGE_W-1:0] + PAGE_ONE};
                  end
               end
               default: next_state = D_IDLE;
            endcase
         end else if (scl_fall && bitcnt == BIT_ACK) begin
            next_sda_en_n = 1'b1;
            next_bitcnt   = BIT_ZERO;
            next_state    = pending;
            if (pending == D_RD) begin
               next_outbyte  = rd_byte;
               next_sda_en_n = rd_byte[BYTE_MSB];
               next_bitcnt   = BIT_ONE;
            end
         end
      end
      next_selected = (next_state != D_IDLE) && (next_state != D_DEV);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state             <= D_IDLE;
         pending           <= D_IDLE;
         bitcnt            <= BIT_ZERO;
         shreg             <= 8'h00;
         outbyte           <= 8'h00;
         addr              <= ADDR_RESET;
         ahi               <= 4'h0;
         alt               <= 1'b0;
         mack              <= 1'b0;
         sda_en_n          <= 1'b1;
         selected          <= 1'b0;
         link.dev_sda_en_n <= 1'b1;
         link.dev_sda_out  <= 1'b0;
      end else begin
         state             <= next_state;
         pending           <= next_pending;
         bitcnt            <= next_bitcnt;
         shreg             <= next_shreg;
         outbyte           <= next_outbyte;
         addr              <= next_addr;
         ahi               <= next_ahi;
         alt               <= next_alt;
         mack              <= next_mack;
         sda_en_n          <= next_sda_en_n;
         selected          <= next_selected;
         link.dev_sda_en_n <= next_sda_en_n;
         link.dev_sda_out  <= 1'b0;
      end
   end

endmodule

// ===== design/eeprom_read_host.sv
/*
 * Bus master end of the two-wire link: issues current-address or
 * random/sequential reads and returns the bytes on a user port.
 * Assumes the EEPROM end on the shared link; SCL is made here by
 * a divider from clk.
 */
`timescale 1ns/1ns
module eeprom_read_host
   import eeprom_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Link
   eeprom_link_if.host               link,
   // Command
   input  wire logic                 cmd_valid,
   input  wire logic                 cmd_alt,
   input  wire logic [2:0]           cmd_cs,
   input  wire logic                 cmd_set_addr,
   input  wire logic [ADDR_W-1:0]    cmd_addr,
   input  wire logic [7:0]           cmd_count,
   output logic                      cmd_ready,
   // Read data
   output logic [7:0]                rd_data,
   output logic                      rd_valid,
   output logic                      done,
   output logic                      nack_err
);
   import eeprom_pkg::*;

   // ******************************
   // SDA synchroniser
   // ******************************
   logic sda_m, sda_s;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         sda_m <= link.sda;
         sda_s <= sda_m;
      end
   end

   // ******************************
   // Sequencer
   // ******************************
   host_state_e       state, next_state;
   tx_kind_e          kind, next_kind;
   logic [7:0]        qcnt, next_qcnt, remain, next_remain;
   logic [1:0]        qtr, next_qtr;
   logic [3:0]        bitn, next_bitn;
   logic [7:0]        rxbyte, next_rxbyte, next_rd_data;
   logic              alt, next_alt, set_addr, next_set_addr;
   logic [2:0]        cs, next_cs;
   logic [ADDR_W-1:0] addr, next_addr;
   logic              scl, next_scl, sda_en_n, next_sda_en_n;
   logic              next_cmd_ready, next_rd_valid, next_done;
   logic              next_nack_err, tick;
   logic [7:0]        txbyte;

   assign tick = (qcnt == 8'h00);

   always_comb begin
      unique case (kind)
         K_DEVW:  txbyte = {alt ? TYPE_ALT : TYPE_MAIN, cs, RW_WRITE};
         K_AHI:   txbyte = {HI_PAD, addr[ADDR_W-1:8]};
         K_ALO:   txbyte = addr[7:0];
         K_DEVR:  txbyte = {alt ? TYPE_ALT : TYPE_MAIN, cs, RW_READ};
         default: txbyte = 8'h00;
      endcase
   end

   always_comb begin
      next_state     = state;
      next_kind      = kind;
      next_qcnt      = qcnt;
      next_remain    = remain;
      next_qtr       = qtr;
      next_bitn      = bitn;
      next_rxbyte    = rxbyte;
      next_rd_data   = rd_data;
      next_alt       = alt;
      next_set_addr  = set_addr;
      next_cs        = cs;
      next_addr      = addr;
      next_scl       = scl;
      next_sda_en_n  = sda_en_n;
      next_cmd_ready = cmd_ready;
      next_rd_valid  = 1'b0;
      next_done      = 1'b0;
      next_nack_err  = nack_err;
      if (state == H_IDLE) begin
         next_scl      = 1'b1;
         next_sda_en_n = 1'b1;
         if (cmd_valid && cmd_ready) begin
            next_cmd_ready = 1'b0;
            next_nack_err  = 1'b0;
            next_alt       = cmd_alt;
            next_cs        = cmd_cs;
            next_set_addr  = cmd_set_addr;
            next_addr      = cmd_addr;
            next_remain    = cmd_count;
            next_kind      = cmd_set_addr ? K_DEVW : K_DEVR;
            next_state     = H_START;
            next_qtr       = 2'h0;
            next_qcnt      = QTR_RELOAD;
         end
      end else if (!tick) begin
         next_qcnt = qcnt - 8'h01;
      end else begin
         next_qcnt = QTR_RELOAD;
         next_qtr  = qtr + 2'h1;
         unique case (state)
            H_START: begin
               unique case (qtr)
                  2'h0: begin
                     next_sda_en_n = 1'b1;
                     next_scl      = 1'b0;
                  end
                  2'h1: next_scl = 1'b1;
                  2'h2: next_sda_en_n = 1'b0;
                  default: begin
                     next_scl   = 1'b0;
                     next_state = H_TX;
                     next_bitn  = BIT_ZERO;
                  end
               endcase
            end
            H_TX: begin
               unique case (qtr)
                  2'h0: next_sda_en_n = (bitn == BIT_BYTE) ? 1'b1 :
                                        txbyte[~bitn[2:0]];
                  2'h1: next_scl = 1'b1;
                  2'h2: ;
                  default: begin
                     next_scl  = 1'b0;
                     next_bitn = bitn + BIT_ONE;
                     if (bitn == BIT_BYTE) begin
                        next_bitn = BIT_ZERO;
                        if (sda_s) begin
                           next_nack_err = 1'b1;
                           next_state    = H_STOP;
                        end else begin
                           unique case (kind)
                              K_DEVW: next_kind = K_AHI;
                              K_AHI:  next_kind = K_ALO;
                              K_ALO: begin
                                 next_kind  = K_DEVR;
                                 next_state = H_START;
                              end
                              default: next_state = H_RX;
                           endcase
                        end
                     end
                  end
               endcase
            end
            H_RX: begin
               unique case (qtr)
                  // Ack every byte but the last one
                  2'h0: next_sda_en_n = (bitn == BIT_BYTE) ?
                                        (remain == CNT_ONE) : 1'b1;
                  2'h1: next_scl = 1'b1;
                  2'h2: ;
                  default: begin
                     next_scl  = 1'b0;
                     next_bitn = bitn + BIT_ONE;
                     if (bitn < BIT_BYTE) begin
                        next_rxbyte = {rxbyte[6:0], sda_s};
                     end
                     if (bitn == BIT_LAST) begin
                        next_rd_data  = {rxbyte[6:0], sda_s};
                        next_rd_valid = 1'b1;
                     end
                     if (bitn == BIT_BYTE) begin
                        next_bitn   = BIT_ZERO;
                        next_remain = remain - CNT_ONE;
                        if (remain == CNT_ONE) begin
                           next_state = H_STOP;
                        end
                     end
                  end
               endcase
            end
            H_STOP: begin
               unique case (qtr)
                  2'h0: begin
                     next_sda_en_n = 1'b0;
                     next_scl      = 1'b0;
                  end
                  2'h1: next_scl = 1'b1;
                  2'h2: next_sda_en_n = 1'b1;
                  default: begin
                     next_state     = H_IDLE;
                     next_done      = 1'b1;
                     next_cmd_ready = 1'b1;
                  end
               endcase
            end
            default: next_state = H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state              <= H_IDLE;
         kind               <= K_DEVR;
         qcnt               <= QTR_RELOAD;
         remain             <= 8'h00;
         qtr                <= 2'h0;
         bitn               <= BIT_ZERO;
         rxbyte             <= 8'h00;
         rd_data            <= 8'h00;
         alt                <= 1'b0;
         set_addr           <= 1'b0;
         cs                 <= 3'h0;
         addr               <= ADDR_RESET;
         scl                <= 1'b1;
         sda_en_n           <= 1'b1;
         cmd_ready          <= 1'b1;
         rd_valid           <= 1'b0;
         done               <= 1'b0;
         nack_err           <= 1'b0;
         link.scl           <= 1'b1;
         link.host_sda_en_n <= 1'b1;
         link.host_sda_out  <= 1'b0;
      end else begin
         state              <= next_state;
         kind               <= next_kind;
         qcnt               <= next_qcnt;
         remain             <= next_remain;
         qtr                <= next_qtr;
         bitn               <= next_bitn;
         rxbyte             <= next_rxbyte;
         rd_data            <= next_rd_data;
         alt                <= next_alt;
         set_addr           <= next_set_addr;
         cs                 <= next_cs;
         addr               <= next_addr;
         scl                <= next_scl;
         sda_en_n           <= next_sda_en_n;
         cmd_ready          <= next_cmd_ready;
         rd_valid           <= next_rd_valid;
         done               <= next_done;
         nack_err           <= next_nack_err;
         link.scl           <= next_scl;
         link.host_sda_en_n <= next_sda_en_n;
         link.host_sda_out  <= 1'b0;
      end
   end

endmodule

// ===== sim/eeprom_i2c_read_path_assertions.sv
/* Wire checks on the link between the two ends.
   Assumes the host clk and rst; sda is the resolved wire. */
`timescale 1ns/1ns
module eeprom_i2c_read_path_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_out,
   input wire logic host_sda_en_n,
   input wire logic dev_sda_out,
   input wire logic dev_sda_en_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_dev_pull_only: assert property (!dev_sda_out)
      else $error("device drove sda high");
   chk_host_pull_only: assert property (!host_sda_out)
      else $error("host drove sda high");
   chk_dev_edge_low: assert property (
      $changed(dev_sda_en_n) |-> !scl && !$past(scl, 2))
      else $error("device moved sda off scl low");
   chk_dev_hold_high: assert property (
      scl && $past(scl) |-> $stable(dev_sda_en_n))
      else $error("device moved sda in scl high");
   chk_start_free: assert property (
      $fell(sda) && scl && $past(scl) |-> dev_sda_en_n)
      else $error("device held sda at start");
   chk_stop_standby: assert property (
      $rose(sda) && scl && $past(scl) |=> dev_sda_en_n [*8])
      else $error("device drove sda after stop");
   chk_stop_by_host: assert property (
      $rose(sda) && scl && $past(scl) |-> !$past(host_sda_en_n))
      else $error("stop not made by host");
   chk_scl_high_len: assert property ($rose(scl) |=> scl [*8])
      else $error("scl high too short");
   chk_scl_low_len: assert property ($fell(scl) |=> !scl [*8])
      else $error("scl low too short");
endmodule

// ===== sim/eeprom_i2c_read_path_tb_top.sv
/* Bench: host and device ends joined on one link.
   Assumes contents are preloaded through the device load port. */
`timescale 1ns/1ns
module eeprom_i2c_read_path_tb_top;
   import eeprom_pkg::*;
   logic        clk, rst, cmd_valid, cmd_alt, cmd_set_addr, load_en;
   logic        cmd_ready, rd_valid, done, nack_err, selected, id_locked;
   logic [2:0]  cmd_cs;
   logic [11:0] cmd_addr, load_addr;
   logic [7:0]  cmd_count, rd_data, load_data, got[$];
   load_sel_e   load_sel;
   int          fail_count, comparisons;
   eeprom_link_if link();
   eeprom_read_host i_eeprom_read_host (.clk(clk), .rst(rst),
      .link(link.host), .cmd_valid(cmd_valid), .cmd_alt(cmd_alt),
      .cmd_cs(cmd_cs), .cmd_set_addr(cmd_set_addr), .cmd_addr(cmd_addr),
      .cmd_count(cmd_count), .cmd_ready(cmd_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .done(done), .nack_err(nack_err));
   eeprom_read_device i_eeprom_read_device (.clk(clk), .rst(rst),
      .link(link.device), .chip_select_bit_high(1'b1),
      .chip_select_bit_mid(1'b0), .chip_select_bit_low(1'b1),
      .id_locked(id_locked), .load_en(load_en), .load_sel(load_sel),
      .load_addr(load_addr), .load_data(load_data), .selected(selected));
   eeprom_i2c_read_path_assertions i_eeprom_i2c_read_path_assertions (
      .clk(clk), .rst(rst), .scl(link.scl), .sda(link.sda),
      .host_sda_out(link.host_sda_out), .host_sda_en_n(link.host_sda_en_n),
      .dev_sda_out(link.dev_sda_out), .dev_sda_en_n(link.dev_sda_en_n));
   // Distinct content per area so a wrong area or index shows
   function automatic logic [7:0] ex(input logic alt, input logic [11:0] a);
      if (!alt) return a[7:0] ^ {a[11:8], a[11:8]};
      if (a[11:10] == 2'h0) return 8'h40 + 8'(a[4:0]);
      if (a[11:10] == 2'h2) return 8'h80 + 8'(a[3:0]);
      return UNDEF_BYTE;
   endfunction
   task automatic chk(input string nm, input logic [7:0] s, e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic ld(input load_sel_e sl, input logic [11:0] a,
                     input logic [7:0] d);
      @(posedge clk);
      load_en <= 1'b1;
      load_sel <= sl;
      load_addr <= a;
      load_data <= d;
   endtask
   // One command; c is the byte count expected back (0 on refusal)
   task automatic rd(input string nm, input logic alt, set,
                     input logic [11:0] a, input logic [7:0] n, c);
      logic seen;
      got.delete();
      seen = 1'b0;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_alt <= alt;
      cmd_set_addr <= set;
      cmd_addr <= a;
      cmd_count <= n;
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (int k = 0; k < 30000; k++) begin
         @(negedge clk);
         if (rd_valid === 1'b1) got.push_back(rd_data);
         if (selected === 1'b1) seen = 1'b1;
         if (done === 1'b1) break;
      end
      chk({nm, " done"}, 8'(done), 8'h01);
      if (done !== 1'b1) stop_test();
      chk({nm, " count"}, 8'(got.size()), c);
      chk({nm, " nack"}, 8'(nack_err), 8'(c == 0));
      chk({nm, " sel"}, 8'(seen), 8'(c != 0));
      chk({nm, " idle"}, 8'(selected), 8'h00);
      chk({nm, " ready"}, 8'(cmd_ready), 8'h01);
      foreach (got[i]) chk(nm, got[i], ex(alt, a + 12'(i)));
      $display("test %s done", nm);
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #8000000;
      fail_count++;
      stop_test();
   end
   initial begin
      {rst, cmd_valid, cmd_alt, cmd_set_addr, load_en, id_locked} = 6'h20;
      {cmd_addr, load_addr, cmd_count, load_data} = 40'h0;
      cmd_cs = 3'h5;
      load_sel = LD_MAIN;
      fail_count = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4096; i++) begin
         ld(LD_MAIN, 12'(i), ex(1'b0, 12'(i)));
         if (i < 32) ld(LD_ID, 12'(i), ex(1'b1, 12'(i)));
         if (i < 16) ld(LD_SER, 12'(i), ex(1'b1, 12'h800 + 12'(i)));
      end
      @(posedge clk);
      load_en <= 1'b0;
      rd("wrap", 1'b0, 1'b1, 12'hffe, 8'h3, 8'h3);
      rd("current", 1'b0, 1'b0, 12'h001, 8'h1, 8'h1);
      // A locked page stays readable
      @(posedge clk);
      id_locked <= 1'b1;
      rd("idpage", 1'b1, 1'b1, 12'h01e, 8'h2, 8'h2);
      rd("serial", 1'b1, 1'b1, 12'h800, 8'h10, 8'h10);
      rd("undef", 1'b1, 1'b1, 12'hc00, 8'h1, 8'h1);
      rd("main", 1'b0, 1'b1, 12'h801, 8'h1, 8'h1);
      rd("shared", 1'b1, 1'b0, 12'h802, 8'h1, 8'h1);
      @(posedge clk);
      cmd_cs <= 3'h4;
      rd("nosel", 1'b0, 1'b0, 12'h000, 8'h1, 8'h0);
      stop_test();
   end
endmodule
